// ==== design/dpio_port.sv ====
/*
  Two parallel I/O ports with function select, direction, data latches, peripheral
  default inputs and a small level 4 interrupt pending and in-service block.
  Assumes one 40 MHz clock, a plain register port and external pin pads that
  resolve the pin level from the output enables.
*/
`timescale 1ns/1ps
module dpio_port
  import dpio_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_pa_pin,
  output logic [15:0] o_pa_pin,
  output logic [15:0] o_pa_oe,
  input wire logic [15:0] i_pa_periph_out,
  input wire logic [15:0] i_pa_periph_oe,
  output logic [15:0] o_pa_periph_in,
  input wire logic [11:0] i_pb_pin,
  output logic [11:0] o_pb_pin,
  output logic [11:0] o_pb_oe,
  input wire logic [7:0] i_pb_periph_out,
  input wire logic [7:0] i_pb_periph_oe,
  output logic [7:0] o_pb_periph_in,
  input wire logic i_refresh_req,
  input wire logic i_ch1_event_pend,
  input wire logic i_iack,
  output logic o_int_req,
  output logic [4:0] o_ack_src
);

  localparam dpio_state_t ST_RESET = '{
    pa_cnt: `DPIO_RST_PA_CNT,
    pa_ddr: `DPIO_RST_PA_DDR,
    pa_lat: 16'h0000,
    pb_cnt: `DPIO_RST_PB_CNT,
    pb_ddr: `DPIO_RST_PB_DDR,
    pb_lat: 12'h000,
    global_interrupt_mode_reg: `DPIO_RST_GLOBAL_INTERRUPT_MODE_REG,
    interrupt_mask_reg: 16'h0000,
    interrupt_pending_reg: 16'h0000,
    interrupt_in_service_reg: 16'h0000,
    system_control_reg: `DPIO_RST_SCR,
    pa_s1: 16'h0000,
    pa_s2: 16'h0000,
    pb_s1: 12'h000,
    pb_s2: 12'h000,
    pb_prev: 12'h000,
    rdata: 16'h0000,
    ack_src: 5'h00
  };

  dpio_state_t st;
  dpio_state_t next_st;

  logic [15:0] pa_rd_val;
  logic [11:0] pb_rd_val;
  logic [3:0] pb_edge;
  logic [15:0] cand;
  logic [4:0] win_idx;
  logic [4:0] isr_top;
  logic win_valid;
  logic refresh_mode;

  function automatic logic [4:0] top_bit(input logic [15:0] v);
    logic [4:0] t;
    t = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        t = i[4:0];
      end
    end
    return t;
  endfunction

  assign refresh_mode = st.system_control_reg[`DPIO_SCR_REFRESH_BIT];

  // Pin drive for the first port.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (st.pa_cnt[i]) begin
        o_pa_pin[i] = i_pa_periph_out[i];
        o_pa_oe[i] = i_pa_periph_oe[i];
      end else begin
        o_pa_pin[i] = st.pa_lat[i];
        o_pa_oe[i] = st.pa_ddr[i];
      end
    end
  end

  // Inputs seen by the serial and DMA peripherals.
  always_comb begin
    o_pa_periph_in = (st.pa_cnt & st.pa_s2) | (~st.pa_cnt & `DPIO_PA_IDLE_LEVEL);
    if (!st.pa_cnt[`DPIO_BIT_PA_SERIAL_CH2_TX_CLOCK]) begin
      o_pa_periph_in[`DPIO_BIT_PA_SERIAL_CH2_TX_CLOCK] = o_pa_periph_in[`DPIO_BIT_PA_SERIAL_CH2_RX_CLOCK];
    end
    if (!st.pa_cnt[`DPIO_BIT_PA_SERIAL_CH3_TX_CLOCK]) begin
      o_pa_periph_in[`DPIO_BIT_PA_SERIAL_CH3_TX_CLOCK] = o_pa_periph_in[`DPIO_BIT_PA_SERIAL_CH3_RX_CLOCK];
    end
  end

  // Pin drive for the second port.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (st.pb_cnt[i]) begin
        o_pb_pin[i] = i_pb_periph_out[i];
        o_pb_oe[i] = i_pb_periph_oe[i];
      end else begin
        o_pb_pin[i] = st.pb_lat[i];
        o_pb_oe[i] = st.pb_ddr[i];
      end
    end
    if (st.pb_cnt[`DPIO_BIT_PB_WATCHDOG_OUTPUT]) begin
      o_pb_pin[`DPIO_BIT_PB_WATCHDOG_OUTPUT] = 1'b0;
      o_pb_oe[`DPIO_BIT_PB_WATCHDOG_OUTPUT] = ~i_pb_periph_out[`DPIO_BIT_PB_WATCHDOG_OUTPUT];
    end
    for (int i = 8; i < 12; i++) begin
      o_pb_pin[i] = st.pb_lat[i];
      o_pb_oe[i] = st.pb_ddr[i];
    end
    if (refresh_mode) begin
      o_pb_pin[8] = i_refresh_req;
      o_pb_oe[8] = 1'b1;
    end
    o_pb_periph_in = (st.pb_cnt & st.pb_s2[7:0]) | (~st.pb_cnt & `DPIO_PB_IDLE_LEVEL);
  end

  // Read-back values of the data registers.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (st.pa_cnt[i]) begin
        pa_rd_val[i] = i_pa_periph_oe[i] ? i_pa_periph_out[i] : st.pa_s2[i];
      end else begin
        pa_rd_val[i] = st.pa_ddr[i] ? st.pa_lat[i] : st.pa_s2[i];
      end
    end
    for (int i = 0; i < 12; i++) begin
      pb_rd_val[i] = o_pb_oe[i] ? o_pb_pin[i] : st.pb_s2[i];
    end
  end

  // Falling edges on the upper second-port pins while they are general inputs.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pb_edge[i] = st.pb_prev[8 + i] & ~st.pb_s2[8 + i] & ~st.pb_ddr[8 + i];
    end
    if (refresh_mode) begin
      pb_edge[0] = 1'b0;
    end
  end

  // Priority pick: higher bit number is higher priority within level 4.
  always_comb begin
    cand = st.interrupt_pending_reg & st.interrupt_mask_reg & `DPIO_INT_IMPL;
    win_idx = top_bit(cand);
    isr_top = top_bit(st.interrupt_in_service_reg);
    win_valid = (cand != 16'h0000) && ((st.interrupt_in_service_reg == 16'h0000) || (win_idx > isr_top));
  end

  assign o_int_req = st.global_interrupt_mode_reg[`DPIO_GLOBAL_INTERRUPT_MODE_REG_EN_BIT] & win_valid;
  assign o_rdata = st.rdata;
  assign o_ack_src = st.ack_src;

  always_comb begin
    next_st = st;
    next_st.pa_s1 = i_pa_pin;
    next_st.pa_s2 = st.pa_s1;
    next_st.pb_s1 = i_pb_pin;
    next_st.pb_s2 = st.pb_s1;
    next_st.pb_prev = st.pb_s2;
    if (i_wr) begin
      unique case (i_addr)
        `DPIO_OFS_PA_CNT: next_st.pa_cnt = i_wdata;
        `DPIO_OFS_PA_DDR: next_st.pa_ddr = i_wdata;
        `DPIO_OFS_PA_DAT: next_st.pa_lat = i_wdata;
        `DPIO_OFS_PB_CNT: next_st.pb_cnt = i_wdata[7:0];
        `DPIO_OFS_PB_DDR: next_st.pb_ddr = i_wdata[11:0];
        `DPIO_OFS_PB_DAT: next_st.pb_lat = i_wdata[11:0];
        `DPIO_OFS_GLOBAL_INTERRUPT_MODE_REG: next_st.global_interrupt_mode_reg = i_wdata;
        `DPIO_OFS_IMR: next_st.interrupt_mask_reg = i_wdata & `DPIO_INT_IMPL;
        `DPIO_OFS_IPR: next_st.interrupt_pending_reg = st.interrupt_pending_reg & ~i_wdata;
        `DPIO_OFS_ISR: next_st.interrupt_in_service_reg = st.interrupt_in_service_reg & ~i_wdata;
        `DPIO_OFS_SCR: next_st.system_control_reg = i_wdata;
        default: begin
        end
      endcase
    end
    if (i_iack) begin
      next_st.ack_src = win_valid ? win_idx : 5'h00;
      if (win_valid) begin
        next_st.interrupt_in_service_reg[win_idx[3:0]] = 1'b1;
        next_st.interrupt_pending_reg[win_idx[3:0]] = 1'b0;
      end
    end
    // Edges set after every clear, so a clash keeps the request.
    if (pb_edge[0]) begin
      next_st.interrupt_pending_reg[`DPIO_INT_PB8] = 1'b1;
    end
    if (pb_edge[1]) begin
      next_st.interrupt_pending_reg[`DPIO_INT_PB9] = 1'b1;
    end
    if (pb_edge[2]) begin
      next_st.interrupt_pending_reg[`DPIO_INT_PB10] = 1'b1;
    end
    if (pb_edge[3]) begin
      next_st.interrupt_pending_reg[`DPIO_INT_PB11] = 1'b1;
    end
    next_st.interrupt_pending_reg[`DPIO_INT_SERIAL1] = i_ch1_event_pend;
    next_st.rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        `DPIO_OFS_PA_CNT: next_st.rdata = st.pa_cnt;
        `DPIO_OFS_PA_DDR: next_st.rdata = st.pa_ddr;
        `DPIO_OFS_PA_DAT: next_st.rdata = pa_rd_val;
        `DPIO_OFS_PB_CNT: next_st.rdata = {8'h00, st.pb_cnt};
        `DPIO_OFS_PB_DDR: next_st.rdata = {4'h0, st.pb_ddr};
        `DPIO_OFS_PB_DAT: next_st.rdata = {4'h0, pb_rd_val};
        `DPIO_OFS_GLOBAL_INTERRUPT_MODE_REG: next_st.rdata = st.global_interrupt_mode_reg;
        `DPIO_OFS_IMR: next_st.rdata = st.interrupt_mask_reg;
        `DPIO_OFS_IPR: next_st.rdata = st.interrupt_pending_reg;
        `DPIO_OFS_ISR: next_st.rdata = st.interrupt_in_service_reg;
        `DPIO_OFS_SCR: next_st.rdata = st.system_control_reg;
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Checks.
  logic [3:0] pb_pend;
  assign pb_pend = {st.interrupt_pending_reg[`DPIO_INT_PB11], st.interrupt_pending_reg[`DPIO_INT_PB10],
                    st.interrupt_pending_reg[`DPIO_INT_PB9], st.interrupt_pending_reg[`DPIO_INT_PB8]};

  sequence s_ack_taken;
    i_iack && win_valid && (win_idx != 5'(`DPIO_INT_SERIAL1)) && (pb_edge == 4'h0);
  endsequence

  sequence s_ack_done;
    (st.ack_src == $past(win_idx)) ##0 st.interrupt_in_service_reg[st.ack_src[3:0]] ##0 !st.interrupt_pending_reg[st.ack_src[3:0]];
  endsequence

  property p_reset_state;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !$past(i_nrst) |-> (st.pa_cnt == 16'h0000) && (st.pa_ddr == 16'h0000) &&
      (st.pb_cnt == 8'h80) && (st.pb_ddr == 12'h000) && (st.global_interrupt_mode_reg == 16'h0000);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Bad state after reset.");

  property p_sync_delay;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    $past(i_nrst, 2) |-> (st.pa_s2 == $past(i_pa_pin, 2)) && (st.pb_s2 == $past(i_pb_pin, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Pin sync is not two stages.");

  property p_edge_pend;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (pb_edge != 4'h0) |=> ((pb_pend & $past(pb_edge)) == $past(pb_edge));
  endproperty
  a_edge_pend: assert property (p_edge_pend) else $error("Falling edge lost.");

  property p_out_no_irq;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (st.pb_ddr[11] && !st.interrupt_pending_reg[`DPIO_INT_PB11] && !(i_wr && i_addr == `DPIO_OFS_PB_DDR))
      |=> !st.interrupt_pending_reg[`DPIO_INT_PB11];
  endproperty
  a_out_no_irq: assert property (p_out_no_irq) else $error("Output pin raised a request.");

  property p_ack_clear;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    s_ack_taken |=> s_ack_done;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("Acknowledge did not move bit.");

  property p_event_pend;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_ch1_event_pend |=> st.interrupt_pending_reg[`DPIO_INT_SERIAL1];
  endproperty
  a_event_pend: assert property (p_event_pend) else $error("Event source not pending.");

  property p_mask;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    o_int_req |-> ((st.interrupt_pending_reg & st.interrupt_mask_reg) != 16'h0000) && st.global_interrupt_mode_reg[`DPIO_GLOBAL_INTERRUPT_MODE_REG_EN_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("Request while masked.");

  property p_read_dat;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd && i_addr == `DPIO_OFS_PA_DAT) |=> (o_rdata == $past(pa_rd_val));
  endproperty
  a_read_dat: assert property (p_read_dat) else $error("Data read-back wrong.");

  property p_tclk;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !st.pa_cnt[`DPIO_BIT_PA_SERIAL_CH2_TX_CLOCK] |-> (o_pa_periph_in[3] == o_pa_periph_in[2]);
  endproperty
  a_tclk: assert property (p_tclk) else $error("Transmit clock not from receive pin.");

  property p_latch_drive;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_wr && i_addr == `DPIO_OFS_PA_DAT) ##1 (st.pa_ddr[0] && !st.pa_cnt[0])
      |-> (o_pa_pin[0] == $past(i_wdata[0])) && o_pa_oe[0];
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("Latch not driven.");

  property p_reserved;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_rd && i_addr == `DPIO_OFS_PB_CNT) |=> (o_rdata[15:8] == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

endmodule

// ==== design/dpio_defs.svh ====
/*
  Constants of the dual parallel I/O port block: register offsets, field positions,
  reset values and the fixed levels seen by peripherals whose pins are reassigned.
  Assumes it is included by its bare name from the package; the port module sees it through the package.
*/
// Overview of operation
// - First port pin is general I/O when select bit is 0, peripheral when 1.
// - General I/O pin is input when direction bit is 0, output when 1.
// - Reset clears first port select and direction bits: all pins become inputs.
// - Data writes always update the latch; latch drives only general outputs.
// - Data read returns latch for outputs and the live pin level for inputs.
// - Peripheral mode ignores direction; data bit shows the peripheral pin state.
// - Reassigned peripheral inputs see ground; the DMA done input sees high.
// - Reassigned transmit clock pin makes the transmitter use the receive clock pin.
// - DMA request held active low when its pin is general I/O.
// - Reset makes second port bit 7 the open-drain watchdog output.
// - Lower second port carries acks, timers, watchdog; timer inputs see ground.
// - Second port bit 8 may serve as refresh request when system control selects.
// - Upper four pins follow direction bits, cleared by reset to inputs.
// - Reset clears global interrupt mode register to block spurious interrupts.
// - Falling edge on an upper input pin requests a level 4 interrupt, fixed priority.
// - Each of the four pin requests is masked by its own mask bit.
// - Sources without event register lose pending bit during acknowledge.
// - Event register source stays pending while unmasked events remain.
// - Reserved bits of port control, direction and data registers read zero.
`ifndef DPIO_DEFS_SVH
`define DPIO_DEFS_SVH
`define DPIO_OFS_PA_CNT 8'h00
`define DPIO_OFS_PA_DDR 8'h04
`define DPIO_OFS_PA_DAT 8'h08
`define DPIO_OFS_PB_CNT 8'h0C
`define DPIO_OFS_PB_DDR 8'h10
`define DPIO_OFS_PB_DAT 8'h14
`define DPIO_OFS_GLOBAL_INTERRUPT_MODE_REG 8'h18
`define DPIO_OFS_IMR 8'h1C
`define DPIO_OFS_IPR 8'h20
`define DPIO_OFS_ISR 8'h24
`define DPIO_OFS_SCR 8'h28
`define DPIO_RST_PA_CNT 16'h0000
`define DPIO_RST_PA_DDR 16'h0000
`define DPIO_RST_PB_CNT 8'h80
`define DPIO_RST_PB_DDR 12'h000
`define DPIO_RST_GLOBAL_INTERRUPT_MODE_REG 16'h0000
`define DPIO_RST_SCR 16'h0000
`define DPIO_PA_IDLE_LEVEL 16'h8000
`define DPIO_PB_IDLE_LEVEL 8'h00
`define DPIO_BIT_PA_SERIAL_CH2_RX_CLOCK 2
`define DPIO_BIT_PA_SERIAL_CH2_TX_CLOCK 3
`define DPIO_BIT_PA_SERIAL_CH3_RX_CLOCK 10
`define DPIO_BIT_PA_SERIAL_CH3_TX_CLOCK 11
`define DPIO_BIT_PB_WATCHDOG_OUTPUT 7
`define DPIO_GLOBAL_INTERRUPT_MODE_REG_EN_BIT 0
`define DPIO_SCR_REFRESH_BIT 0
`define DPIO_INT_PB8 1
`define DPIO_INT_PB9 7
`define DPIO_INT_PB10 14
`define DPIO_INT_PB11 15
`define DPIO_INT_SERIAL1 13
`define DPIO_INT_IMPL 16'hE082
`endif

// ==== design/dpio_pkg.sv ====
/*
  Types of the dual parallel I/O port block.
  Assumes dpio_defs.svh is on the include path.
*/
package dpio_pkg;
  `include "dpio_defs.svh"

  typedef struct packed {
    logic [15:0] pa_cnt;
    logic [15:0] pa_ddr;
    logic [15:0] pa_lat;
    logic [7:0] pb_cnt;
    logic [11:0] pb_ddr;
    logic [11:0] pb_lat;
    logic [15:0] global_interrupt_mode_reg;
    logic [15:0] interrupt_mask_reg;
    logic [15:0] interrupt_pending_reg;
    logic [15:0] interrupt_in_service_reg;
    logic [15:0] system_control_reg;
    logic [15:0] pa_s1;
    logic [15:0] pa_s2;
    logic [11:0] pb_s1;
    logic [11:0] pb_s2;
    logic [11:0] pb_prev;
    logic [15:0] rdata;
    logic [4:0] ack_src;
  } dpio_state_t;
endpackage

// ==== test/dpio_board.sv ====
/*
  Board model for both parallel ports: each pin shows the port's drive while the
  port enables it, and the board's own level otherwise.
  Assumes the board holds a defined level on every pin that the port releases.
*/
`timescale 1ns/1ps
module dpio_board (
  input wire logic [15:0] i_pa_drv,
  input wire logic [15:0] i_pa_oe,
  input wire logic [15:0] i_pa_ext,
  output logic [15:0] o_pa_lvl,
  input wire logic [11:0] i_pb_drv,
  input wire logic [11:0] i_pb_oe,
  input wire logic [11:0] i_pb_ext,
  output logic [11:0] o_pb_lvl
);
  // A driven pin shows the port value, a released pin the board level.
  assign o_pa_lvl = (i_pa_oe & i_pa_drv) | (~i_pa_oe & i_pa_ext);
  assign o_pb_lvl = (i_pb_oe & i_pb_drv) | (~i_pb_oe & i_pb_ext);
endmodule

// ==== test/tb_top.sv ====
/*
  Self-checking bench of the dual parallel port block: register tasks, pin levels
  through the board model, peripheral inputs and the level 4 request path.
  Assumes the design package and the board model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  n_tests++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top;
  import dpio_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic iack = 1'b0;
  logic pend = 1'b0;
  logic refr = 1'b0;
  logic [15:0] pa_ext = 16'h0000;
  logic [15:0] pa_pout = 16'h1234;
  logic [15:0] pa_poe = 16'hF0F0;
  logic [11:0] pb_ext = 12'hFFF;
  logic [7:0] pb_pout = 8'h00;
  logic [7:0] pb_poe = 8'h55;
  logic [15:0] rdata, pa_drv, pa_oe, pa_lvl, pa_pi;
  logic [11:0] pb_drv, pb_oe, pb_lvl;
  logic [7:0] pb_pi;
  logic int_req;
  logic [4:0] ack_src;
  int failures = 0;
  int n_tests = 0;

  dpio_port dut (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pa_pin(pa_lvl), .o_pa_pin(pa_drv),
    .o_pa_oe(pa_oe), .i_pa_periph_out(pa_pout), .i_pa_periph_oe(pa_poe),
    .o_pa_periph_in(pa_pi), .i_pb_pin(pb_lvl), .o_pb_pin(pb_drv), .o_pb_oe(pb_oe),
    .i_pb_periph_out(pb_pout), .i_pb_periph_oe(pb_poe), .o_pb_periph_in(pb_pi),
    .i_refresh_req(refr), .i_ch1_event_pend(pend), .i_iack(iack),
    .o_int_req(int_req), .o_ack_src(ack_src));
  dpio_board board (.i_pa_drv(pa_drv), .i_pa_oe(pa_oe), .i_pa_ext(pa_ext),
    .o_pa_lvl(pa_lvl), .i_pb_drv(pb_drv), .i_pb_oe(pb_oe), .i_pb_ext(pb_ext),
    .o_pb_lvl(pb_lvl));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask

  task automatic do_ack();
    @(posedge clk);
    iack <= 1'b1;
    @(posedge clk);
    iack <= 1'b0;
    #1;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #40000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h00, 16'h0000, "a_select");
    rd_chk(8'h04, 16'h0000, "a_dir");
    rd_chk(8'h0C, 16'h0080, "b_select");
    rd_chk(8'h10, 16'h0000, "b_dir");
    rd_chk(8'h18, 16'h0000, "global_interrupt_mode_reg");
    `CHK("watchdog_output_oe", 1'b1, pb_oe[7])
    $display("test reset done");
    wr_reg(8'h04, 16'hFFFF);
    wr_reg(8'h08, 16'hA5C3);
    `CHK("a_oe", 16'hFFFF, pa_oe)
    `CHK("a_drive", 16'hA5C3, pa_drv)
    rd_chk(8'h08, 16'hA5C3, "a_data_out");
    wr_reg(8'h04, 16'h00FF);
    pa_ext <= 16'h3C00;
    repeat (4) @(posedge clk);
    rd_chk(8'h08, 16'h3CC3, "a_data_mix");
    `CHK("a_oe_mix", 16'h00FF, pa_oe)
    $display("test port a gpio done");
    wr_reg(8'h00, 16'hFFFF);
    `CHK("a_periph_oe", 16'hF0F0, pa_oe)
    `CHK("a_periph_drv", 16'h1030, pa_drv & 16'hF0F0)
    repeat (2) @(posedge clk);
    rd_chk(8'h08, 16'h1C30, "a_periph_data");
    wr_reg(8'h00, 16'h0000);
    pa_ext <= 16'hFFFF;
    repeat (4) @(posedge clk);
    #1;
    `CHK("a_fixed_in", 16'h8000, pa_pi & 16'hF7F7)
    wr_reg(8'h00, 16'h0404);
    repeat (2) @(posedge clk);
    #1;
    `CHK("tx_from_rx", 16'h8C0C, pa_pi)
    rd_chk(8'h2C, 16'h0000, "unmapped");
    $display("test port a peripheral done");
    wr_reg(8'h0C, 16'h0000);
    `CHK("timer_in", 8'h00, pb_pi & 8'h28)
    wr_reg(8'h0C, 16'hFFFF);
    rd_chk(8'h0C, 16'h00FF, "b_select_rsv");
    `CHK("b_periph_oe", 7'h55, pb_oe[6:0])
    wr_reg(8'h10, 16'hFFFF);
    rd_chk(8'h10, 16'h0FFF, "b_dir_rsv");
    wr_reg(8'h10, 16'h0000);
    $display("test port b done");
    wr_reg(8'h18, 16'h0001);
    wr_reg(8'h1C, 16'hE082);
    pb_ext <= 12'hDFF;
    repeat (4) @(posedge clk);
    rd_chk(8'h20, 16'h0080, "pend_pin9");
    `CHK("req_on", 1'b1, int_req)
    do_ack();
    `CHK("ack_pin9", 5'd7, ack_src)
    rd_chk(8'h24, 16'h0080, "in_service");
    rd_chk(8'h20, 16'h0000, "pend_auto_clr");
    wr_reg(8'h24, 16'h0080);
    rd_chk(8'h24, 16'h0000, "isr_w1c");
    wr_reg(8'h1C, 16'h0000);
    pb_ext <= 12'h9FF;
    repeat (4) @(posedge clk);
    rd_chk(8'h20, 16'h4000, "pend_masked");
    `CHK("req_masked", 1'b0, int_req)
    wr_reg(8'h20, 16'h4000);
    wr_reg(8'h1C, 16'hE082);
    wr_reg(8'h14, 16'h0800);
    wr_reg(8'h10, 16'h0800);
    wr_reg(8'h14, 16'h0000);
    repeat (4) @(posedge clk);
    rd_chk(8'h20, 16'h0000, "no_edge_out");
    $display("test pin interrupts done");
    wr_reg(8'h28, 16'h0001);
    @(posedge clk);
    refr <= 1'b1;
    #1;
    `CHK("refresh_pin", 1'b1, pb_drv[8])
    @(posedge clk);
    pend <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h20, 16'h2000, "event_pend");
    do_ack();
    `CHK("ack_serial1", 5'd13, ack_src)
    rd_chk(8'h20, 16'h2000, "event_stays");
    pend <= 1'b0;
    wr_reg(8'h24, 16'h2000);
    $display("test event source done");
    give_verdict();
  end
endmodule
